// File: stepper_pkg.sv
// constants for the stepper sequencer; assumes an APB master with
// 32-bit data and byte addresses on paddr.
package stepper_pkg;
  localparam int ADDR_W   = 8;
  localparam int PSS_W    = 13;
  localparam int CNT_W    = 16;
  localparam int RAMP_N   = 48;
  localparam int RAMP_AW  = 6;

  // register byte addresses
  localparam logic [7:0] A_MODE   = 8'h00;
  localparam logic [7:0] A_CTRL   = 8'h04;
  localparam logic [7:0] A_IEN    = 8'h08;
  localparam logic [7:0] A_FLAG   = 8'h0C;
  localparam logic [7:0] A_IOC    = 8'h10;
  localparam logic [7:0] A_CNT    = 8'h14;
  localparam logic [7:0] A_STEP   = 8'h18;
  localparam logic [7:0] A_GAP    = 8'h1C;
  localparam logic [7:0] A_PDATA  = 8'h20;
  localparam logic [7:0] A_PDIR   = 8'h24;
  localparam logic [7:0] A_SLUE   = 8'h28;
  localparam logic [7:0] A_CONST  = 8'h2C;
  localparam logic [7:0] A_HOLD   = 8'h30;
  localparam logic [7:0] A_RIDX   = 8'h34;
  localparam logic [7:0] A_RDAT   = 8'h38;
  localparam logic [7:0] A_STAT   = 8'h3C;

  // field positions
  localparam int B_CTS   = 7;
  localparam int B_CCLR  = 7;
  localparam int B_CKS   = 4;
  localparam int B_IOB2  = 6;
  localparam int B_IOA2  = 2;
  localparam int B_STEPF = 0;
  localparam int B_GAPF  = 1;

  // clock select codes
  localparam logic [2:0] CKS_DIV1 = 3'h0;
  localparam logic [2:0] CKS_DIV2 = 3'h1;
  localparam logic [2:0] CKS_DIV4 = 3'h2;
  localparam logic [2:0] CKS_DIV8 = 3'h3;

  // reset values
  localparam logic [15:0] RST_STEP = 16'hFFFF;
  localparam logic [15:0] RST_GAP  = 16'h1000;
  localparam logic [2:0]  RST_PIDX = 3'h7;

  // pattern table, entry i at bits 4i+3..4i: 08 0C 04 06 02 03 01 09
  localparam logic [31:0] PAT_TABLE = 32'h9132_64C8;

  typedef enum logic [8:0] {
    ST_IDLE      = 9'h001,
    ST_FWD_UP    = 9'h002,
    ST_FWD_CONST = 9'h004,
    ST_FWD_DOWN  = 9'h008,
    ST_STOP_F    = 9'h010,
    ST_REV_UP    = 9'h020,
    ST_REV_CONST = 9'h040,
    ST_REV_DOWN  = 9'h080,
    ST_STOP_R    = 9'h100
  } seq_state_t;
endpackage : stepper_pkg

// File: stepper_two_phase_sequencer.sv
// stepper two-phase sequencer: APB registers, prescaler, compare
// timer, excitation sequencer and phase output register.
// assumes a single pclk domain and synchronous pin inputs.
//
// The implementer's own choices: the APB register port and the register addresses.
`timescale 1ns/1ns
module stepper_two_phase_sequencer (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        ext_clk_in,
  output logic             phase_a_out,
  output logic             phase_b_out,
  output logic             phase_a_inv_out,
  output logic             phase_b_inv_out,
  output logic      [3:0]  phase_oe,
  output logic             step_irq_req,
  output logic             nonoverlap_irq_req
);

  ////////////////////////////////////////////////////////////////////
  // registers
  logic [7:0]  timer_mode_reg;
  logic [7:0]  timer_control_reg;
  logic [7:0]  timer_irq_enable_reg;
  logic [1:0]  timer_flag_reg;
  logic [7:0]  compare_io_control_reg;
  logic [15:0] step_timer_count;
  logic [15:0] step_period_compare;
  logic [15:0] nonoverlap_compare;
  logic [3:0]  phase_output_direction;
  logic [15:0] slue_steps_r;
  logic [15:0] const_steps_r;
  logic [15:0] hold_steps_r;
  logic [5:0]  ramp_idx_r;
  logic [15:0] ramp_mem [stepper_pkg::RAMP_N];
  logic [12:0] clock_prescaler;
  logic        ext_d_r;
  logic [3:0]  phase_r;
  logic [2:0]  pidx_r;
  logic [5:0]  rptr_r;
  logic [15:0] step_cnt_r;
  stepper_pkg::seq_state_t state_r;
  stepper_pkg::seq_state_t state_nxt;

  ////////////////////////////////////////////////////////////////////
  // bus decode: one wait state, write lands when pready is seen.
  // pready is registered, so read data is captured a cycle before it
  // is shown; the extra wait state buys a clean flop on prdata.
  wire acc      = psel & penable;
  wire wr_en    = acc & pwrite & pready;
  wire rd_take  = acc & ~pready;
  wire hit_mode = (paddr == stepper_pkg::A_MODE);
  wire hit_ctrl = (paddr == stepper_pkg::A_CTRL);
  wire hit_ien  = (paddr == stepper_pkg::A_IEN);
  wire hit_flag = (paddr == stepper_pkg::A_FLAG);
  wire hit_ioc  = (paddr == stepper_pkg::A_IOC);
  wire hit_cnt  = (paddr == stepper_pkg::A_CNT);
  wire hit_step = (paddr == stepper_pkg::A_STEP);
  wire hit_gap  = (paddr == stepper_pkg::A_GAP);
  wire hit_pdat = (paddr == stepper_pkg::A_PDATA);
  wire hit_pdir = (paddr == stepper_pkg::A_PDIR);
  wire hit_slue = (paddr == stepper_pkg::A_SLUE);
  wire hit_cons = (paddr == stepper_pkg::A_CONST);
  wire hit_hold = (paddr == stepper_pkg::A_HOLD);
  wire hit_ridx = (paddr == stepper_pkg::A_RIDX);
  wire hit_rdat = (paddr == stepper_pkg::A_RDAT);
  wire hit_stat = (paddr == stepper_pkg::A_STAT);
  wire mapped   = hit_mode | hit_ctrl | hit_ien | hit_flag | hit_ioc
                | hit_cnt | hit_step | hit_gap | hit_pdat | hit_pdir
                | hit_slue | hit_cons | hit_hold | hit_ridx | hit_rdat
                | hit_stat;

  // read mux, narrower registers sit low with zeros above
  wire [31:0] rd_mux =
      hit_mode ? {24'h000000, timer_mode_reg} :
      hit_ctrl ? {24'h000000, timer_control_reg} :
      hit_ien  ? {24'h000000, timer_irq_enable_reg} :
      hit_flag ? {30'h00000000, timer_flag_reg} :
      hit_ioc  ? {24'h000000, compare_io_control_reg} :
      hit_cnt  ? {16'h0000, step_timer_count} :
      hit_step ? {16'h0000, step_period_compare} :
      hit_gap  ? {16'h0000, nonoverlap_compare} :
      hit_pdat ? {28'h0000000, phase_r} :
      hit_pdir ? {28'h0000000, phase_output_direction} :
      hit_slue ? {16'h0000, slue_steps_r} :
      hit_cons ? {16'h0000, const_steps_r} :
      hit_hold ? {16'h0000, hold_steps_r} :
      hit_ridx ? {26'h0000000, ramp_idx_r} :
      hit_rdat ? {16'h0000, ramp_mem[ramp_idx_r]} :
      hit_stat ? {20'h00000, pidx_r, 9'(state_r)} :
      32'h00000000;

  // bus answer flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= 32'h00000000;
      pslverr <= 1'b0;
    end else begin
      pready  <= rd_take;
      pslverr <= rd_take & ~mapped;
      if (rd_take) prdata <= rd_mux;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // free-running prescaler
  // never stopped or cleared, so the divided ticks keep a fixed phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) clock_prescaler <= 13'h0000;
    else          clock_prescaler <= clock_prescaler + 13'h0001;
  end

  // external clock edge; input already synchronous
  // a level held high counts once: only the rising edge is a tick
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) ext_d_r <= 1'b0;
    else          ext_d_r <= ext_clk_in;
  end

  // tick select; div8 gives compare over clock/8
  wire [2:0] cks = timer_control_reg[stepper_pkg::B_CKS +: 3];
  wire tick =
      (cks == stepper_pkg::CKS_DIV1) ? 1'b1 :
      (cks == stepper_pkg::CKS_DIV2) ? (&clock_prescaler[0:0]) :
      (cks == stepper_pkg::CKS_DIV4) ? (&clock_prescaler[1:0]) :
      (cks == stepper_pkg::CKS_DIV8) ? (&clock_prescaler[2:0]) :
      (ext_clk_in & ~ext_d_r);

  // counting gated by start; compare only in output mode
  wire run    = timer_mode_reg[stepper_pkg::B_CTS];
  wire oc_a   = ~compare_io_control_reg[stepper_pkg::B_IOA2];
  wire oc_b   = ~compare_io_control_reg[stepper_pkg::B_IOB2];
  wire cclr   = timer_control_reg[stepper_pkg::B_CCLR];
  wire step_m = run & tick & oc_a & (step_timer_count == step_period_compare);
  wire gap_m  = run & tick & oc_b & (step_timer_count == nonoverlap_compare);

  ////////////////////////////////////////////////////////////////////
  // counter starts at zero; clear on step match
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)                step_timer_count <= 16'h0000;
    else if (wr_en && hit_cnt)   step_timer_count <= pwdata[15:0];
    else if (run && tick) begin
      if (step_m && cclr)        step_timer_count <= 16'h0000;
      else                       step_timer_count <= step_timer_count + 16'h0001;
    end
  end

  // sticky flags, write one clears, a new match wins
  // losing a match to a racing clear would drop a step request
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) timer_flag_reg <= 2'h0;
    else begin
      timer_flag_reg <= (timer_flag_reg & ~((wr_en && hit_flag) ? pwdata[1:0] : 2'h0))
                      | {gap_m, step_m};
    end
  end

  // interrupt requests gated by enables
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      step_irq_req       <= 1'b0;
      nonoverlap_irq_req <= 1'b0;
    end else begin
      step_irq_req       <= timer_flag_reg[stepper_pkg::B_STEPF]
                          & timer_irq_enable_reg[stepper_pkg::B_STEPF];
      nonoverlap_irq_req <= timer_flag_reg[stepper_pkg::B_GAPF]
                          & timer_irq_enable_reg[stepper_pkg::B_GAPF];
    end
  end

  // plain control registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_mode_reg         <= 8'h00;
      timer_control_reg      <= 8'h00;
      timer_irq_enable_reg   <= 8'h00;
      compare_io_control_reg <= 8'h00;
      nonoverlap_compare     <= stepper_pkg::RST_GAP;
      phase_output_direction <= 4'h0;
      slue_steps_r           <= 16'h0000;
      const_steps_r          <= 16'h0000;
      hold_steps_r           <= 16'h0000;
    end else if (wr_en) begin
      if (hit_mode) timer_mode_reg         <= pwdata[7:0];
      if (hit_ctrl) timer_control_reg      <= pwdata[7:0];
      if (hit_ien)  timer_irq_enable_reg   <= pwdata[7:0];
      if (hit_ioc)  compare_io_control_reg <= pwdata[7:0];
      if (hit_gap)  nonoverlap_compare     <= pwdata[15:0];
      if (hit_pdir) phase_output_direction <= pwdata[3:0];
      if (hit_slue) slue_steps_r           <= pwdata[15:0];
      if (hit_cons) const_steps_r          <= pwdata[15:0];
      if (hit_hold) hold_steps_r           <= pwdata[15:0];
    end
  end

  ////////////////////////////////////////////////////////////////////
  // ramp table, written through index with auto increment
  // no reset: contents are undefined until software loads them
  wire ramp_wr = wr_en & hit_rdat;
  always_ff @(posedge pclk) begin
    if (ramp_wr) ramp_mem[ramp_idx_r] <= pwdata[15:0];
  end

  // index wraps after the last entry
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)             ramp_idx_r <= 6'h00;
    else if (wr_en && hit_ridx) ramp_idx_r <= pwdata[5:0];
    else if (ramp_wr)
      ramp_idx_r <= (ramp_idx_r == 6'(stepper_pkg::RAMP_N - 1)) ? 6'h00
                                                               : ramp_idx_r + 6'h01;
  end

  ////////////////////////////////////////////////////////////////////
  // sequencer phase decode
  // direction is a property of the state, not a separate bit
  wire in_up   = (state_r == stepper_pkg::ST_FWD_UP)
               | (state_r == stepper_pkg::ST_REV_UP);
  wire in_down = (state_r == stepper_pkg::ST_FWD_DOWN)
               | (state_r == stepper_pkg::ST_REV_DOWN);
  wire in_fwd  = (state_r == stepper_pkg::ST_FWD_UP)
               | (state_r == stepper_pkg::ST_FWD_CONST)
               | in_down & (state_r == stepper_pkg::ST_FWD_DOWN);
  wire in_rev  = (state_r == stepper_pkg::ST_REV_UP)
               | (state_r == stepper_pkg::ST_REV_CONST)
               | (state_r == stepper_pkg::ST_REV_DOWN);
  wire moving  = in_fwd | in_rev;

  // constant speed: fixed step count, period untouched
  wire in_const = (state_r == stepper_pkg::ST_FWD_CONST)
                | (state_r == stepper_pkg::ST_REV_CONST);

  // step count of the current phase; zero behaves as one step,
  // so a cleared count register can never skip a phase
  wire [15:0] limit =
      in_up    ? {8'h00, slue_steps_r[7:0]} :
      in_down  ? {8'h00, slue_steps_r[15:8]} :
      in_const ? const_steps_r :
      hold_steps_r;
  wire last_step = (step_cnt_r + 16'h0001) >= limit;

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      stepper_pkg::ST_IDLE:      if (run) state_nxt = stepper_pkg::ST_FWD_UP;
      stepper_pkg::ST_FWD_UP:    state_nxt = stepper_pkg::ST_FWD_CONST;
      stepper_pkg::ST_FWD_CONST: state_nxt = stepper_pkg::ST_FWD_DOWN;
      stepper_pkg::ST_FWD_DOWN:  state_nxt = stepper_pkg::ST_STOP_F;
      stepper_pkg::ST_STOP_F:    state_nxt = stepper_pkg::ST_REV_UP;
      stepper_pkg::ST_REV_UP:    state_nxt = stepper_pkg::ST_REV_CONST;
      stepper_pkg::ST_REV_CONST: state_nxt = stepper_pkg::ST_REV_DOWN;
      stepper_pkg::ST_REV_DOWN:  state_nxt = stepper_pkg::ST_STOP_R;
      stepper_pkg::ST_STOP_R:    state_nxt = stepper_pkg::ST_FWD_UP;
      default:                   state_nxt = stepper_pkg::ST_IDLE;
    endcase
  end

  // wait idle until started; advance on the last step match
  // clearing start freezes the state; restarting resumes mid-phase
  wire idle_go = (state_r == stepper_pkg::ST_IDLE) & run;
  wire advance = ~(state_r == stepper_pkg::ST_IDLE) & step_m & last_step;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r    <= stepper_pkg::ST_IDLE;
      step_cnt_r <= 16'h0000;
    end else if (idle_go || advance) begin
      state_r    <= state_nxt;
      step_cnt_r <= 16'h0000;
    end else if (step_m) begin
      step_cnt_r <= step_cnt_r + 16'h0001;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // ramp pointer: up walks forward, down walks back
  wire [5:0] rptr_dn = (rptr_r == 6'h00) ? 6'h00 : rptr_r - 6'h01;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) rptr_r <= 6'h00;
    else if (idle_go || (advance && in_down)) rptr_r <= 6'h00;
    else if (step_m && in_up && rptr_r != 6'(stepper_pkg::RAMP_N - 1))
      rptr_r <= rptr_r + 6'h01;
    else if (step_m && in_down) rptr_r <= rptr_dn;
  end

  // step period; hardware reload wins over a software write
  // only during slue; the constant phase keeps the value loaded last
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)               step_period_compare <= stepper_pkg::RST_STEP;
    else if (step_m && in_up)   step_period_compare <= ramp_mem[rptr_r];
    else if (step_m && in_down) step_period_compare <= ramp_mem[rptr_dn];
    else if (wr_en && hit_step) step_period_compare <= pwdata[15:0];
  end

  ////////////////////////////////////////////////////////////////////
  // pattern index: odd entries pairs, even entries singles
  wire       odd     = pidx_r[0];
  wire [2:0] step_ix = in_fwd ? (odd ? pidx_r + 3'h2 : pidx_r + 3'h1)
                              : (odd ? pidx_r - 3'h2 : pidx_r - 3'h1);
  wire [2:0] gap_ix  = in_fwd ? pidx_r + 3'h1 : pidx_r - 3'h1;
  // stop states never change the pattern
  // limitation: a gap compare at or above the step compare skips the
  // single-phase entry, so software must keep the gap the shorter one
  // gap match moves to the single phase, step match to the pair
  wire pat_step = moving & step_m;
  wire pat_gap  = moving & gap_m & ~step_m & odd;
  wire [2:0] pidx_nxt = pat_step ? step_ix : gap_ix;

  // all four phases change on one edge from one register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pidx_r  <= stepper_pkg::RST_PIDX;
      phase_r <= 4'h0;
    end else if (pat_step || pat_gap) begin
      pidx_r  <= pidx_nxt;
      phase_r <= stepper_pkg::PAT_TABLE[{pidx_nxt, 2'b00} +: 4];
    end
  end

  ////////////////////////////////////////////////////////////////////
  // bit order A, B, ~A, ~B; direction drives enables
  // registered pins cost a cycle of latency but never glitch
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_a_out     <= 1'b0;
      phase_b_out     <= 1'b0;
      phase_a_inv_out <= 1'b0;
      phase_b_inv_out <= 1'b0;
      phase_oe        <= 4'h0;
    end else begin
      phase_a_out     <= phase_r[3] & phase_output_direction[3];
      phase_b_out     <= phase_r[2] & phase_output_direction[2];
      phase_a_inv_out <= phase_r[1] & phase_output_direction[1];
      phase_b_inv_out <= phase_r[0] & phase_output_direction[0];
      phase_oe        <= phase_output_direction;
    end
  end

endmodule : stepper_two_phase_sequencer

// File: stepper_checker_properties.sv
// checker for the stepper sequencer: apb timing and phase pins
// assumes one pclk domain, presetn asynchronous active low
`timescale 1ns/1ns
module stepper_checker (
  input wire logic       pclk,
  input wire logic       presetn,
  input wire logic       psel,
  input wire logic       penable,
  input wire logic       pwrite,
  input wire logic [7:0] paddr,
  input wire logic       pready,
  input wire logic       pslverr,
  input wire logic       phase_a_out,
  input wire logic       phase_b_out,
  input wire logic       phase_a_inv_out,
  input wire logic       phase_b_inv_out,
  input wire logic [3:0] phase_oe
);
  // pin vector and write strobe to the direction register
  wire logic [3:0] ph  = {phase_a_out, phase_b_out, phase_a_inv_out, phase_b_inv_out};
  wire logic       acc = psel & penable;
  wire logic       dwr = acc & pwrite & pready & (paddr == stepper_pkg::A_PDIR);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  ////////////////////////////////////////////////////////////////
  property p_reset_idle; $rose(presetn) |-> (ph == 4'h0) && !pready; endproperty
  property p_ready_pulse; pready |=> !pready; endproperty
  property p_ready_wait; $rose(acc) |-> ##[1:2] pready; endproperty
  property p_ready_cause; pready |-> acc && $past(acc); endproperty
  property p_err_ready; pslverr |-> pready; endproperty
  property p_pin_enable; (ph & ~phase_oe) == 4'h0; endproperty
  property p_no_opposite; !(ph[3] && ph[1]) && !(ph[2] && ph[0]); endproperty
  // a pair only ever drops to one of its own phases
  property p_gap_drop;
    ($countones($past(ph)) == 2) && (ph != $past(ph)) && $stable(phase_oe)
      |-> ($countones(ph) == 1) && ((ph & $past(ph)) == ph);
  endproperty
  property p_pair_grow;
    ($countones($past(ph)) == 1) && (ph != $past(ph)) && $stable(phase_oe)
      |-> ($countones(ph) == 2) && ((ph & $past(ph)) == $past(ph));
  endproperty
  property p_oe_cause; $changed(phase_oe) |-> $past(dwr) || $past(dwr, 2); endproperty
  a_reset_idle: assert property (p_reset_idle) else $error("pins not idle after reset");
  a_ready_pulse: assert property (p_ready_pulse) else $error("pready longer than one cycle");
  a_ready_wait: assert property (p_ready_wait) else $error("pready late");
  a_ready_cause: assert property (p_ready_cause) else $error("pready without access");
  a_err_ready: assert property (p_err_ready) else $error("pslverr without pready");
  a_pin_enable: assert property (p_pin_enable) else $error("pin high while not output");
  a_no_opposite: assert property (p_no_opposite) else $error("opposite phases on");
  a_gap_drop: assert property (p_gap_drop) else $error("bad pair to single change");
  a_pair_grow: assert property (p_pair_grow) else $error("bad single to pair change");
  a_oe_cause: assert property (p_oe_cause) else $error("direction change unasked");
  c_pair: cover property (ph == 4'h0C);
  c_err: cover property (pslverr);
  c_gap: cover property ($countones(ph) == 1);
endmodule : stepper_checker
bind stepper_two_phase_sequencer stepper_checker chk (.pclk, .presetn, .psel, .penable,
  .pwrite, .paddr, .pready, .pslverr, .phase_a_out, .phase_b_out, .phase_a_inv_out,
  .phase_b_inv_out, .phase_oe);

// File: motor_driver_model.sv
// behavioural motor driver stage: logs the first 32 new excitations, counts every one
// assumes pins sampled on pclk; undriven inputs pulled low
`timescale 1ns/1ns
module motor_driver_model (
  input wire logic       pclk,
  input wire logic [3:0] pin,
  input wire logic [3:0] oe
);
  // pull-downs: a floating input reads as de-energised
  wire logic [3:0] level = pin & oe;
  logic [3:0]      last_r = 4'h0;
  logic [3:0]      pat_r [0:31];
  time             tim_r [0:31];
  int              n_r = 0;
  int              shoot_r = 0;
  always @(posedge pclk) begin
    if (level !== last_r) begin
      if (n_r < 32) begin
        pat_r[n_r] <= level;
        tim_r[n_r] <= $time;
      end
      n_r <= n_r + 1;
    end
    last_r <= level;
    // both windings of a phase on would short the bridge
    if ((level[3] && level[1]) || (level[2] && level[0])) shoot_r <= shoot_r + 1;
  end
endmodule : motor_driver_model

// File: tb.sv
// self-checking bench for the stepper sequencer
// assumes the driver model on the pins and a 20 MHz pclk
`timescale 1ns/1ns
module tb;
  logic        pclk, presetn, psel, penable, pwrite, err;
  logic        ext_clk_in = 1'b0;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        pready, pslverr, pa, pb, pai, pbi, sirq, girq;
  logic [3:0]  oe;
  int          fails = 0, total_checks = 0, cyc = 0;
  time         t1;
  logic [3:0]  exp_pat [0:14] = '{4'h8, 4'hC, 4'h4, 4'h6, 4'h2, 4'h3, 4'h2, 4'h6,
                                   4'h4, 4'hC, 4'h8, 4'h9, 4'h8, 4'hC, 4'h4};
  stepper_two_phase_sequencer dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .ext_clk_in, .phase_a_out(pa), .phase_b_out(pb),
    .phase_a_inv_out(pai), .phase_b_inv_out(pbi), .phase_oe(oe), .step_irq_req(sirq),
    .nonoverlap_irq_req(girq));
  motor_driver_model drv (.pclk, .pin({pa, pb, pai, pbi}), .oe);
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  // watchdog, and an external count source of one rise per 4 cycles
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc % 2 == 1) ext_clk_in <= ~ext_clk_in;
    if (cyc == 10000) begin
      fails = fails + 1;
      summarize();
    end
  end
  ////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // one apb transfer; holds the request until pready is sampled
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    // no cycle budget here: only the watchdog ends a stuck wait
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    t1 = $time;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(rd, exp);
  endtask : rchk
  ////////////////////////////////////////////////////////////////
  // reset values
  task automatic t_reset();
    check(32'({pa, pb, pai, pbi, oe}), 32'h0);
    rchk(stepper_pkg::A_CNT, 32'h0);
    rchk(stepper_pkg::A_STEP, 32'h0000_FFFF);
    rchk(stepper_pkg::A_GAP, 32'h0000_1000);
    rchk(stepper_pkg::A_STAT, 32'h0000_0E01);
    apb(1'b1, stepper_pkg::A_IOC, 32'h0000_0044);
    rchk(stepper_pkg::A_IOC, 32'h0000_0044);
    apb(1'b1, stepper_pkg::A_IOC, 32'h0);
    apb(1'b0, 8'hF0, 32'h0);
    check({rd[30:0], err}, 32'h1);
  endtask : t_reset
  // full forward, stop, reverse, stop run
  task automatic t_seq();
    int n = 0;
    int d = 0;
    int base;
    apb(1'b1, stepper_pkg::A_PDIR, 32'h0000_000F);
    apb(1'b1, stepper_pkg::A_RIDX, 32'h0);
    apb(1'b1, stepper_pkg::A_RDAT, 32'h0000_0007);
    apb(1'b1, stepper_pkg::A_STEP, 32'h0000_0007);
    apb(1'b1, stepper_pkg::A_GAP, 32'h0000_0002);
    apb(1'b1, stepper_pkg::A_SLUE, 32'h0000_0101);
    apb(1'b1, stepper_pkg::A_CONST, 32'h0000_0001);
    apb(1'b1, stepper_pkg::A_HOLD, 32'h0000_0001);
    apb(1'b1, stepper_pkg::A_CTRL, 32'h0000_0080);
    base = drv.n_r;
    apb(1'b1, stepper_pkg::A_MODE, 32'h0000_0080);
    while (drv.n_r < base + 15 && n < 3000) begin
      @(posedge pclk);
      n++;
    end
    for (int i = 0; i < 15; i++) begin
      check(32'(drv.pat_r[base + i]), 32'(exp_pat[i]));
      if (i > 0) d = int'((drv.tim_r[base + i] - drv.tim_r[base + i - 1]) / 50);
      if (i == 6 || i == 12) check(32'(d >= 8), 32'h1);
      else if (i > 0 && i != 7 && i != 13)
        check(32'(d), ($countones(exp_pat[i]) == 1) ? 32'h3 : 32'h5);
    end
    check(32'(drv.shoot_r), 32'h0);
  endtask : t_seq
  task automatic t_flags();
    logic [31:0] v;
    apb(1'b1, stepper_pkg::A_MODE, 32'h0);
    apb(1'b1, stepper_pkg::A_IEN, 32'h0000_0001);
    apb(1'b0, stepper_pkg::A_CNT, 32'h0);
    v = rd;
    rchk(stepper_pkg::A_CNT, v);
    rchk(stepper_pkg::A_FLAG, 32'h0000_0003);
    check(32'({girq, sirq}), 32'h1);
    apb(1'b1, stepper_pkg::A_IEN, 32'h0000_0002);
    rchk(stepper_pkg::A_IEN, 32'h0000_0002);
    check(32'({girq, sirq}), 32'h2);
    apb(1'b1, stepper_pkg::A_FLAG, 32'h0000_0003);
    rchk(stepper_pkg::A_FLAG, 32'h0);
    check(32'({girq, sirq}), 32'h0);
    // compares switched off: the count runs past both values silently
    apb(1'b1, stepper_pkg::A_IOC, 32'h0000_0044);
    apb(1'b1, stepper_pkg::A_STEP, 32'h0000_0002);
    apb(1'b1, stepper_pkg::A_GAP, 32'h0000_0001);
    apb(1'b1, stepper_pkg::A_CNT, 32'h0);
    apb(1'b1, stepper_pkg::A_MODE, 32'h0000_0080);
    apb(1'b1, stepper_pkg::A_MODE, 32'h0);
    rchk(stepper_pkg::A_CNT, 32'h0000_0004);
    rchk(stepper_pkg::A_FLAG, 32'h0);
    apb(1'b1, stepper_pkg::A_IOC, 32'h0);
  endtask : t_flags
  // tick rate of each count source
  task automatic t_clock();
    time s;
    int  d;
    apb(1'b1, stepper_pkg::A_STEP, 32'h0000_FFFF);
    apb(1'b1, stepper_pkg::A_GAP, 32'h0000_FFFF);
    for (int c = 0; c < 5; c++) begin
      apb(1'b1, stepper_pkg::A_CTRL, 32'(c) << 4);
      apb(1'b1, stepper_pkg::A_CNT, 32'h0);
      apb(1'b1, stepper_pkg::A_MODE, 32'h0000_0080);
      s = t1;
      repeat (60) @(posedge pclk);
      apb(1'b1, stepper_pkg::A_MODE, 32'h0);
      d = int'((t1 - s) / 50);
      rchk(stepper_pkg::A_CNT, 32'(d / ((c == 4) ? 4 : (1 << c))));
    end
  endtask : t_clock
  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : summarize
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_seq();
    t_flags();
    t_clock();
    summarize();
  end
endmodule : tb
